// File: design/qsc_sram_end.sv
/*
 sram end: lock period sequencing, dll reset detection, read and
 write state machines and the four beat burst address engines.
 assumes the link pins are asynchronous to clk_in and are synced here.
*/
`timescale 1ns/1ps
module qsc_sram_end (
   input wire logic clk_in,
   input wire logic rst_in,
   qsc_link_if.sram link,
   output logic ready_out,
   output logic dll_locked_out,
   output logic dll_bypass_out,
   output logic term_clk_on_out,
   output logic term_data_on_out,
   output logic rd_beat_valid_out,
   output qsc_pkg::qsc_addr_t rd_beat_addr_out,
   output logic wr_beat_valid_out,
   output qsc_pkg::qsc_addr_t wr_beat_addr_out
);
   import qsc_pkg::*;

   localparam int SYNC_W = 6 + 2 * ADDR_W; // width of sampled pins

   // linear burst address: start plus beat index
   function automatic qsc_addr_t burst_addr(input qsc_addr_t base,
      input logic [1:0] beat);
      return base + qsc_addr_t'(beat);
   endfunction : burst_addr

   logic [SYNC_W-1:0] pin_raw; // pins as they arrive
   logic [SYNC_W-1:0] sync1_ff; // first stage, read by sync2 only
   logic [SYNC_W-1:0] sync2_ff; // second stage, safe to use
   logic k_s, kb_s, doff_s, rd_s, wr_s, odt_s; // synced controls
   qsc_addr_t rd_a_s, wr_a_s; // synced addresses
   logic k_prev_ff, kb_prev_ff, doff_prev_ff; // edge history
   logic k_rise, kb_rise, doff_rise, clk_moved; // edge events
   logic [STOP_CNT_W-1:0] stop_cnt_ff; // cycles without clock edge
   logic clk_stopped; // clocks static too long
   logic dll_rst; // any dll reset cause
   qsc_init_e init_state_ff; // init sequencer
   logic [LOCK_CNT_W-1:0] lock_cnt_ff; // stable clock cycles seen
   logic ready_ff, dll_locked_ff, bypass_ff; // status
   logic term_clk_ff, term_data_ff; // termination enables
   qsc_rd_e rd_state_ff; // read machine
   qsc_wr_e wr_state_ff; // write machine
   logic rd_p1_v_ff, rd_p2_v_ff, wr_p1_v_ff; // latency pipe valid
   qsc_addr_t rd_p1_a_ff, rd_p2_a_ff, wr_p1_a_ff; // latency pipe addr
   logic rd_take, wr_take; // select seen on a rising edge
   logic eng_go [2]; // burst start per port
   qsc_addr_t eng_base [2]; // burst start address per port
   logic beat_v_ff [2]; // beat strobe per port
   qsc_addr_t beat_a_ff [2]; // beat address per port
   qsc_addr_t base_ff [2]; // held start address
   logic [1:0] cnt_ff [2]; // next beat index
   logic busy_ff [2]; // burst in progress

   assign pin_raw = {link.k, link.kb, link.doff_n, link.rd_n, link.wr_n,
      link.die_termination_ctrl, link.rd_addr, link.wr_addr};
   assign {k_s, kb_s, doff_s, rd_s, wr_s, odt_s, rd_a_s, wr_a_s} =
      sync2_ff;

   // two flop synchroniser for every pin
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else begin
         sync1_ff <= pin_raw;
         sync2_ff <= sync1_ff;
      end
   end

   // edge history of the synced clocks and dll-disable
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         k_prev_ff <= 1'b0;
         kb_prev_ff <= 1'b0;
         doff_prev_ff <= 1'b0;
      end else begin
         k_prev_ff <= k_s;
         kb_prev_ff <= kb_s;
         doff_prev_ff <= doff_s;
      end
   end

   assign k_rise = k_s & ~k_prev_ff;
   assign kb_rise = kb_s & ~kb_prev_ff;
   assign doff_rise = doff_s & ~doff_prev_ff;
   assign clk_moved = (k_s ^ k_prev_ff) | (kb_s ^ kb_prev_ff);
   assign clk_stopped = (stop_cnt_ff == KSTOP_MAX);
   assign dll_rst = clk_stopped | doff_rise;

   // counts cycles with neither clock moving, saturating
   always_ff @(posedge clk_in) begin
      if (rst_in || clk_moved) begin
         stop_cnt_ff <= '0;
      end else if (!clk_stopped) begin
         stop_cnt_ff <= stop_cnt_ff + 1'b1;
      end
   end

   // init sequencer: lock period after reset or any dll reset
   always_ff @(posedge clk_in) begin
      if (rst_in || dll_rst) begin
         init_state_ff <= QSC_INIT_LOCK;
         lock_cnt_ff <= '0;
         ready_ff <= 1'b0;
         dll_locked_ff <= 1'b0;
      end else if (k_rise) begin
         unique case (init_state_ff)
            // count stable clock cycles
            QSC_INIT_LOCK: begin
               if (lock_cnt_ff == LOCK_LAST) begin
                  init_state_ff <= QSC_INIT_READY;
                  ready_ff <= 1'b1;
                  dll_locked_ff <= doff_s;
               end else begin
                  lock_cnt_ff <= lock_cnt_ff + 1'b1;
               end
            end
            // bypass drops lock, rising edge restarts the count
            QSC_INIT_READY: begin
               dll_locked_ff <= dll_locked_ff & doff_s;
            end
         endcase
      end
   end

   // bypass flag and termination enables
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         bypass_ff <= 1'b0;
         term_clk_ff <= 1'b1;
         term_data_ff <= 1'b1;
      end else begin
         bypass_ff <= ~doff_s;
         term_clk_ff <= ~odt_s;
         term_data_ff <= 1'b1;
      end
   end

   assign rd_take = ready_ff & ~rd_s;
   assign wr_take = ready_ff & ~wr_s;

   // read machine and its latency pipe
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rd_state_ff <= QSC_RD_IDLE;
         rd_p1_v_ff <= 1'b0;
         rd_p2_v_ff <= 1'b0;
         rd_p1_a_ff <= '0;
         rd_p2_a_ff <= '0;
      end else if (k_rise) begin
         rd_p1_v_ff <= 1'b0;
         rd_p1_a_ff <= rd_a_s;
         rd_p2_v_ff <= rd_p1_v_ff;
         rd_p2_a_ff <= rd_p1_a_ff;
         unique case (rd_state_ff)
            // a low select starts a read
            QSC_RD_IDLE: begin
               if (rd_take) begin
                  rd_state_ff <= QSC_RD_ACTIVE;
                  rd_p1_v_ff <= 1'b1;
               end
            end
            // second cycle of the burst, a new select is ignored
            QSC_RD_ACTIVE: begin
               rd_state_ff <= QSC_RD_IDLE;
            end
         endcase
      end
   end

   // write machine, data beats follow one cycle later
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_state_ff <= QSC_WR_IDLE;
         wr_p1_v_ff <= 1'b0;
         wr_p1_a_ff <= '0;
      end else if (k_rise) begin
         wr_p1_v_ff <= 1'b0;
         wr_p1_a_ff <= wr_a_s;
         unique case (wr_state_ff)
            // a low select starts a write
            QSC_WR_IDLE: begin
               if (wr_take) begin
                  wr_state_ff <= QSC_WR_ACTIVE;
                  wr_p1_v_ff <= 1'b1;
               end
            end
            // second cycle of the burst, a new select is ignored
            QSC_WR_ACTIVE: begin
               wr_state_ff <= QSC_WR_IDLE;
            end
         endcase
      end
   end

   // read starts after two cycles, or one with the dll bypassed
   assign eng_go[0] = k_rise & (bypass_ff ? rd_p1_v_ff : rd_p2_v_ff);
   assign eng_base[0] = bypass_ff ? rd_p1_a_ff : rd_p2_a_ff;
   assign eng_go[1] = k_rise & wr_p1_v_ff;
   assign eng_base[1] = wr_p1_a_ff;

   // one burst engine per port, beats on both clock rising edges
   for (genvar p = 0; p < 2; p++) begin : g_beat
      always_ff @(posedge clk_in) begin
         if (rst_in) begin
            beat_v_ff[p] <= 1'b0;
            beat_a_ff[p] <= '0;
            base_ff[p] <= '0;
            cnt_ff[p] <= 2'h0;
            busy_ff[p] <= 1'b0;
         end else begin
            beat_v_ff[p] <= 1'b0;
            if (eng_go[p]) begin
               // first beat at the start address
               base_ff[p] <= eng_base[p];
               beat_a_ff[p] <= burst_addr(eng_base[p], 2'h0);
               beat_v_ff[p] <= 1'b1;
               cnt_ff[p] <= 2'h1;
               busy_ff[p] <= 1'b1;
            end else if (busy_ff[p] && (k_rise || kb_rise)) begin
               // later beats step the address linearly
               beat_a_ff[p] <= burst_addr(base_ff[p], cnt_ff[p]);
               beat_v_ff[p] <= 1'b1;
               cnt_ff[p] <= cnt_ff[p] + 2'h1;
               busy_ff[p] <= (cnt_ff[p] != BURST_LAST);
            end
         end
      end
   end

   assign ready_out = ready_ff;
   assign dll_locked_out = dll_locked_ff;
   assign dll_bypass_out = bypass_ff;
   assign term_clk_on_out = term_clk_ff;
   assign term_data_on_out = term_data_ff;
   assign rd_beat_valid_out = beat_v_ff[0];
   assign rd_beat_addr_out = beat_a_ff[0];
   assign wr_beat_valid_out = beat_v_ff[1];
   assign wr_beat_addr_out = beat_a_ff[1];
endmodule : qsc_sram_end

// File: design/qsc_pkg.sv
/*
 shared constants, types and timing counts for the sram end and the
 controller end of the burst sram init and command link.
 assumes one 125 MHz clock for both ends and a synchronous reset.
*/
package qsc_pkg;
   // address width of the burst port
   localparam int ADDR_W = 18;
   // system clock period
   localparam int CLK_PERIOD_PS = 8000;
   // static clock time that resets the dll
   localparam int KSTOP_NS = 30;
   // least time, rounded up to whole cycles
   localparam int KSTOP_CYC = (KSTOP_NS * 1000 + CLK_PERIOD_PS - 1)
      / CLK_PERIOD_PS;
   localparam int STOP_CNT_W = $clog2(KSTOP_CYC + 1);
   localparam logic [STOP_CNT_W-1:0] KSTOP_MAX = STOP_CNT_W'(KSTOP_CYC);
   // stable clock cycles needed to lock
   localparam int LOCK_PERIOD_CYCLES = 2048;
   // controller waits a little longer to cover pin sampling skew
   localparam int LOCK_MARGIN = 2;
   localparam int LOCK_CNT_W = 12;
   localparam logic [LOCK_CNT_W-1:0] LOCK_LAST =
      LOCK_CNT_W'(LOCK_PERIOD_CYCLES - 1);
   localparam logic [LOCK_CNT_W-1:0] HOST_LOCK_LAST =
      LOCK_CNT_W'(LOCK_PERIOD_CYCLES + LOCK_MARGIN - 1);
   // half period of the link clock in system cycles
   localparam int K_HALF_CYCLES = 2;
   localparam logic [1:0] K_HALF_LAST = 2'(K_HALF_CYCLES - 1);
   // length of the dll-disable low pulse for a dll reset
   localparam logic [3:0] DOFF_LOW_CYCLES = 4'h8;
   // last beat index of a burst of four
   localparam logic [1:0] BURST_LAST = 2'h3;
   // address type
   typedef logic [ADDR_W-1:0] qsc_addr_t;
   // init sequencer states
   typedef enum logic {QSC_INIT_LOCK, QSC_INIT_READY} qsc_init_e;
   // read machine states
   typedef enum logic {QSC_RD_IDLE, QSC_RD_ACTIVE} qsc_rd_e;
   // write machine states
   typedef enum logic {QSC_WR_IDLE, QSC_WR_ACTIVE} qsc_wr_e;
endpackage : qsc_pkg

// File: design/qsc_link_if.sv
/*
 link wires between the controller end and the sram end.
 assumes the controller drives every wire; no clock inside.
*/
`timescale 1ns/1ps
interface qsc_link_if;
   import qsc_pkg::*;
   logic k; // true input clock
   logic kb; // complementary input clock
   logic doff_n; // dll disable, low bypasses the dll
   logic rd_n; // read select, active low
   logic wr_n; // write select, active low
   logic die_termination_ctrl; // high picks option two
   qsc_addr_t rd_addr; // read start address
   qsc_addr_t wr_addr; // write start address
   // controller drives the link
   modport ctl (output k, kb, doff_n, rd_n, wr_n, die_termination_ctrl,
      rd_addr, wr_addr);
   // sram end listens
   modport sram (input k, kb, doff_n, rd_n, wr_n, die_termination_ctrl,
      rd_addr, wr_addr);
endinterface : qsc_link_if

// File: design/qsc_ctl_end.sv
/*
 controller end: makes the link clocks by a divider, drives the
 dll-disable pin and issues read and write selects.
 assumes user requests come from logic on clk_in.
*/
`timescale 1ns/1ps
module qsc_ctl_end (
   input wire logic clk_in,
   input wire logic rst_in,
   qsc_link_if.ctl link,
   input wire logic dll_enable_in,
   input wire logic dll_reset_req_in,
   input wire logic clk_stop_in,
   input wire logic term_option2_in,
   input wire logic rd_req_in,
   input wire qsc_pkg::qsc_addr_t rd_addr_in,
   input wire logic wr_req_in,
   input wire qsc_pkg::qsc_addr_t wr_addr_in,
   output logic link_ready_out,
   output logic rd_busy_out,
   output logic wr_busy_out,
   output logic rd_issued_out,
   output logic wr_issued_out
);
   import qsc_pkg::*;

   logic [1:0] div_cnt_ff; // half period divider
   logic k_ff, kb_ff; // link clocks
   logic stop_now, wrap, k_fall_ev, k_rise_ev; // clock events
   logic [STOP_CNT_W-1:0] stop_cnt_ff; // cycles held static
   logic [3:0] low_cnt_ff; // dll-disable low pulse left
   logic doff_ff, doff_prev_ff; // dll-disable pin
   logic [LOCK_CNT_W-1:0] lock_cnt_ff; // mirror of the lock period
   logic ready_ff; // lock period over
   logic rd_pend_ff, wr_pend_ff; // requests waiting
   qsc_addr_t rd_a_ff, wr_a_ff; // waiting addresses
   logic rd_n_ff, wr_n_ff; // selects on the pins
   qsc_addr_t rd_pin_ff, wr_pin_ff; // addresses on the pins
   logic rd_go, wr_go; // issue in this slot
   logic rd_iss_ff, wr_iss_ff, odt_ff; // pulses and option

   // stop only with nothing pending and both selects high on the pins
   assign stop_now = clk_stop_in & ~rd_pend_ff & ~wr_pend_ff &
      rd_n_ff & wr_n_ff;
   assign wrap = ~stop_now & (div_cnt_ff == K_HALF_LAST);
   assign k_fall_ev = wrap & k_ff;
   assign k_rise_ev = wrap & ~k_ff;

   // clock divider, both clocks held static while stopped
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         div_cnt_ff <= 2'h0;
         k_ff <= 1'b0;
         kb_ff <= 1'b1;
      end else if (wrap) begin
         div_cnt_ff <= 2'h0;
         k_ff <= ~k_ff;
         kb_ff <= ~kb_ff;
      end else if (!stop_now) begin
         div_cnt_ff <= div_cnt_ff + 2'h1;
      end
   end

   // length of a clock stop, saturating
   always_ff @(posedge clk_in) begin
      if (rst_in || !stop_now) begin
         stop_cnt_ff <= '0;
      end else if (stop_cnt_ff != KSTOP_MAX) begin
         stop_cnt_ff <= stop_cnt_ff + 1'b1;
      end
   end

   // dll-disable pin with a low pulse on request
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         low_cnt_ff <= 4'h0;
         doff_ff <= 1'b0;
         doff_prev_ff <= 1'b0;
      end else begin
         doff_prev_ff <= doff_ff;
         if (dll_reset_req_in) begin
            low_cnt_ff <= DOFF_LOW_CYCLES;
            doff_ff <= 1'b0;
         end else if (low_cnt_ff != 4'h0) begin
            low_cnt_ff <= low_cnt_ff - 4'h1;
            doff_ff <= 1'b0;
         end else begin
            doff_ff <= dll_enable_in;
         end
      end
   end

   // mirror of the lock period, restarted by any dll reset
   always_ff @(posedge clk_in) begin
      if (rst_in || (doff_ff && !doff_prev_ff) ||
         stop_cnt_ff == KSTOP_MAX) begin
         lock_cnt_ff <= '0;
         ready_ff <= 1'b0;
      end else if (k_rise_ev && !ready_ff) begin
         if (lock_cnt_ff == HOST_LOCK_LAST) begin
            ready_ff <= 1'b1;
         end else begin
            lock_cnt_ff <= lock_cnt_ff + 1'b1;
         end
      end
   end

   // read never in back to back slots, write yields to read
   assign rd_go = rd_pend_ff & ready_ff & rd_n_ff;
   assign wr_go = wr_pend_ff & ready_ff & wr_n_ff & ~rd_go;

   // pending requests, taken one at a time per port
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rd_pend_ff <= 1'b0;
         wr_pend_ff <= 1'b0;
         rd_a_ff <= '0;
         wr_a_ff <= '0;
      end else begin
         if (k_fall_ev && rd_go) begin
            rd_pend_ff <= 1'b0;
         end else if (rd_req_in && !rd_pend_ff) begin
            rd_pend_ff <= 1'b1;
            rd_a_ff <= rd_addr_in;
         end
         if (k_fall_ev && wr_go) begin
            wr_pend_ff <= 1'b0;
         end else if (wr_req_in && !wr_pend_ff) begin
            wr_pend_ff <= 1'b1;
            wr_a_ff <= wr_addr_in;
         end
      end
   end

   // selects change on the falling clock, steady at the rise
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rd_n_ff <= 1'b1;
         wr_n_ff <= 1'b1;
         rd_pin_ff <= '0;
         wr_pin_ff <= '0;
         rd_iss_ff <= 1'b0;
         wr_iss_ff <= 1'b0;
         odt_ff <= 1'b0;
      end else begin
         odt_ff <= term_option2_in;
         rd_iss_ff <= k_fall_ev & rd_go;
         wr_iss_ff <= k_fall_ev & wr_go;
         if (k_fall_ev) begin
            rd_n_ff <= ~rd_go;
            wr_n_ff <= ~wr_go;
            if (rd_go) begin
               rd_pin_ff <= rd_a_ff;
            end
            if (wr_go) begin
               wr_pin_ff <= wr_a_ff;
            end
         end
      end
   end

   assign link.k = k_ff;
   assign link.kb = kb_ff;
   assign link.doff_n = doff_ff;
   assign link.rd_n = rd_n_ff;
   assign link.wr_n = wr_n_ff;
   assign link.die_termination_ctrl = odt_ff;
   assign link.rd_addr = rd_pin_ff;
   assign link.wr_addr = wr_pin_ff;
   assign link_ready_out = ready_ff;
   assign rd_busy_out = rd_pend_ff;
   assign wr_busy_out = wr_pend_ff;
   assign rd_issued_out = rd_iss_ff;
   assign wr_issued_out = wr_iss_ff;
endmodule : qsc_ctl_end

// File: verif/qsc_monitor.sv
/*
 checker on the link wires and the sram end outputs.
 assumes one clock, synchronous active high reset, k made from clk_in.
*/
`timescale 1ns/1ps
module qsc_monitor (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic k,
   input wire logic doff_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic die_termination_ctrl,
   input wire logic ready_out,
   input wire logic term_clk_on_out,
   input wire logic rd_beat_valid_out,
   input wire qsc_pkg::qsc_addr_t rd_beat_addr_out,
   input wire logic wr_beat_valid_out,
   input wire qsc_pkg::qsc_addr_t wr_beat_addr_out
);
   import qsc_pkg::*;
   logic k_q_ff; // k one cycle ago
   logic doff_q_ff; // doff_n one cycle ago
   logic [3:0] stop_ff; // cycles with k unchanged
   logic [12:0] kcnt_ff; // k rises since last dll reset
   logic [1:0] rbeat_ff; // index of next read beat
   logic [1:0] wbeat_ff; // index of next write beat
   logic [5:0] nrdy_ff; // cycles spent not ready
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // pin history
   always_ff @(posedge clk_in) begin
      k_q_ff <= k;
      doff_q_ff <= doff_n;
   end
   // static clock length, saturating
   always_ff @(posedge clk_in) begin
      if (rst_in || k != k_q_ff) stop_ff <= 4'h0;
      else if (stop_ff != 4'hF) stop_ff <= stop_ff + 4'h1;
   end
   // lock progress, restarted by reset, doff rise or clock stop
   always_ff @(posedge clk_in) begin
      if (rst_in || (doff_n && !doff_q_ff) || stop_ff == 4'h4) begin
         kcnt_ff <= 13'h0000;
      end else if (k && !k_q_ff && kcnt_ff != 13'h1FFF) begin
         kcnt_ff <= kcnt_ff + 13'h0001;
      end
   end
   // beat position inside each burst
   always_ff @(posedge clk_in) begin
      if (rst_in) rbeat_ff <= 2'h0;
      else if (rd_beat_valid_out) rbeat_ff <= rbeat_ff + 2'h1;
      if (rst_in) wbeat_ff <= 2'h0;
      else if (wr_beat_valid_out) wbeat_ff <= wbeat_ff + 2'h1;
   end
   // time not ready, saturating
   always_ff @(posedge clk_in) begin
      if (rst_in || ready_out) nrdy_ff <= 6'h00;
      else if (nrdy_ff != 6'h3F) nrdy_ff <= nrdy_ff + 6'h01;
   end
   AST_TERM_CLK: assert property (
      $stable(die_termination_ctrl)[*4] |->
      term_clk_on_out == !die_termination_ctrl)
      else $error("clock termination does not follow option");
   AST_LOCK_MIN: assert property (
      $rose(ready_out) |-> kcnt_ff >= 13'h0800)
      else $error("ready before lock period");
   AST_LOCK_MAX: assert property (
      kcnt_ff == 13'h0808 |-> ready_out)
      else $error("not ready after lock period");
   AST_KSTOP: assert property (
      stop_ff == 4'h4 |-> ##[0:8] !ready_out)
      else $error("clock stop did not reset dll");
   AST_DOFF_RST: assert property (
      $rose(doff_n) |-> ##[1:8] !ready_out)
      else $error("doff rise did not reset dll");
   AST_NO_CMD_LOCK: assert property (
      kcnt_ff < 13'h0800 |-> rd_n && wr_n)
      else $error("select during lock period");
   AST_RD_GAP: assert property (
      $fell(rd_n) |=> !$fell(rd_n) [*7])
      else $error("reads closer than two k periods");
   AST_RD_BURST: assert property (
      rd_beat_valid_out && rbeat_ff != 2'h3 |-> ##1 !rd_beat_valid_out
      ##1 rd_beat_valid_out && rd_beat_addr_out ==
      qsc_addr_t'($past(rd_beat_addr_out, 2) + 1'b1))
      else $error("read burst step wrong");
   AST_WR_BURST: assert property (
      wr_beat_valid_out && wbeat_ff != 2'h3 |-> ##1 !wr_beat_valid_out
      ##1 wr_beat_valid_out && wr_beat_addr_out ==
      qsc_addr_t'($past(wr_beat_addr_out, 2) + 1'b1))
      else $error("write burst step wrong");
   AST_RD_LAT: assert property (
      $fell(rd_n) && ready_out && doff_n |->
      ##[11:13] (rd_beat_valid_out && rbeat_ff == 2'h0))
      else $error("read latency wrong with dll");
   AST_RD_LAT_BP: assert property (
      $fell(rd_n) && ready_out && !doff_n |->
      ##[7:9] (rd_beat_valid_out && rbeat_ff == 2'h0))
      else $error("read latency wrong in bypass");
   AST_WR_LAT: assert property (
      $fell(wr_n) && ready_out |->
      ##[7:9] (wr_beat_valid_out && wbeat_ff == 2'h0))
      else $error("write latency wrong");
   AST_NO_BEAT: assert property (
      nrdy_ff == 6'h3F |-> !rd_beat_valid_out && !wr_beat_valid_out)
      else $error("beat while not ready");
endmodule : qsc_monitor

// File: verif/qdr_sram_dll_init_and_burst_ctl_tb_top.sv
/*
 testbench: both ends joined by the link; locking, every dll reset,
 bypass, termination option and random burst traffic.
 assumes the design sources and the monitor are compiled first.
*/
`timescale 1ns/1ps
module qdr_sram_dll_init_and_burst_ctl_tb_top;
   import qsc_pkg::*;
   localparam int LK = LOCK_PERIOD_CYCLES * 2 * K_HALF_CYCLES; // clks
   logic clk_in = 1'b0; // system clock
   logic rst_in = 1'b1; // synchronous reset
   logic dll_en, dll_rst, kstop, opt2, rd_req, wr_req; // user inputs
   qsc_addr_t rd_a, wr_a; // request addresses
   logic ready, locked, bypass, tclk, tdata, rbv, wbv; // sram outputs
   qsc_addr_t rba, wba; // beat addresses
   logic lrdy, rbusy, wbusy, riss, wiss; // controller outputs
   qsc_addr_t rq[$], wq[$], erq[$], ewq[$]; // seen and expected beats
   int fail_count = 0; // mismatches
   int comparisons = 0; // checks made
   qsc_link_if u_qsc_link_if ();
   qsc_sram_end u_qsc_sram_end (.clk_in(clk_in), .rst_in(rst_in),
      .link(u_qsc_link_if.sram), .ready_out(ready),
      .dll_locked_out(locked), .dll_bypass_out(bypass),
      .term_clk_on_out(tclk), .term_data_on_out(tdata),
      .rd_beat_valid_out(rbv), .rd_beat_addr_out(rba),
      .wr_beat_valid_out(wbv), .wr_beat_addr_out(wba));
   qsc_ctl_end u_qsc_ctl_end (.clk_in(clk_in), .rst_in(rst_in),
      .link(u_qsc_link_if.ctl), .dll_enable_in(dll_en),
      .dll_reset_req_in(dll_rst), .clk_stop_in(kstop),
      .term_option2_in(opt2), .rd_req_in(rd_req), .rd_addr_in(rd_a),
      .wr_req_in(wr_req), .wr_addr_in(wr_a), .link_ready_out(lrdy),
      .rd_busy_out(rbusy), .wr_busy_out(wbusy), .rd_issued_out(riss),
      .wr_issued_out(wiss));
   qsc_monitor u_qsc_monitor (.clk_in(clk_in), .rst_in(rst_in),
      .k(u_qsc_link_if.k), .doff_n(u_qsc_link_if.doff_n),
      .rd_n(u_qsc_link_if.rd_n), .wr_n(u_qsc_link_if.wr_n),
      .die_termination_ctrl(u_qsc_link_if.die_termination_ctrl),
      .ready_out(ready), .term_clk_on_out(tclk),
      .rd_beat_valid_out(rbv), .rd_beat_addr_out(rba),
      .wr_beat_valid_out(wbv), .wr_beat_addr_out(wba));
   // clock
   always #4 clk_in = ~clk_in;
   // beat collection where outputs are settled
   always @(negedge clk_in) begin
      if (rbv === 1'b1) rq.push_back(rba);
      if (wbv === 1'b1) wq.push_back(wba);
   end
   // verdict and end of run
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_of_test
   // one comparison
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk
   // wait on falling edges
   task automatic cyc_n(int n);
      repeat (n) @(negedge clk_in);
   endtask : cyc_n
   // bounded wait for ready, returns cycles taken
   task automatic wait_ready(output int n);
      n = 0;
      while (ready !== 1'b1 && n < 9000) begin
         @(negedge clk_in);
         n++;
      end
   endtask : wait_ready
   // start address: corners first, then random kept inside the space
   function automatic qsc_addr_t rnd_a(int i);
      qsc_addr_t a;
      a = qsc_addr_t'($urandom);
      if (i == 0) a = 18'h3FFFC;
      if (i == 1) a = 18'h00003;
      if (a > 18'h3FFFC) a = 18'h3FFFC;
      return a;
   endfunction : rnd_a
   // one read and one write request in the same cycle
   task automatic req(qsc_addr_t ra, qsc_addr_t wa);
      rd_req = 1'b1;
      wr_req = 1'b1;
      rd_a = ra;
      wr_a = wa;
      @(negedge clk_in);
      rd_req = 1'b0;
      wr_req = 1'b0;
      for (int i = 0; i < 4; i++) begin
         erq.push_back(qsc_addr_t'(ra + i));
         ewq.push_back(qsc_addr_t'(wa + i));
      end
   endtask : req
   // request pair on a ready link, write one k period after the read
   task automatic rw(qsc_addr_t ra, qsc_addr_t wa);
      int t, tr, tw;
      req(ra, wa);
      t = 0;
      tr = -1;
      tw = -1;
      while ((tr < 0 || tw < 0) && t < 40) begin
         if (riss === 1'b1) tr = t;
         if (wiss === 1'b1) tw = t;
         @(negedge clk_in);
         t++;
      end
      chk("wr_after_rd", 2 * K_HALF_CYCLES, tw - tr);
      cyc_n(24);
   endtask : rw
   // compare collected beats with expected, then clear the queues
   task automatic cmpq(string nm);
      chk("rd_beats", erq.size(), rq.size());
      chk("wr_beats", ewq.size(), wq.size());
      for (int i = 0; i < erq.size() && i < rq.size(); i++)
         chk("rd_addr", erq[i], rq[i]);
      for (int i = 0; i < ewq.size() && i < wq.size(); i++)
         chk("wr_addr", ewq[i], wq[i]);
      rq.delete();
      wq.delete();
      erq.delete();
      ewq.delete();
      $display("test %s done", nm);
   endtask : cmpq
   // watchdog
   initial begin
      #(8 * 70000);
      fail_count++;
      end_of_test();
   end
   // main sequence
   initial begin
      int n;
      int s;
      {dll_en, dll_rst, kstop, opt2, rd_req, wr_req} = 6'h20;
      rd_a = '0;
      wr_a = '0;
      s = $urandom(47);
      cyc_n(20);
      chk("rst_tclk", 1, tclk);
      chk("rst_ready", 0, ready);
      rst_in = 1'b0;
      // power-up lock with a request already waiting
      req(rnd_a(2), rnd_a(3));
      cyc_n(8);
      chk("busy_in_lock", 1, rbusy);
      chk("wbusy_in_lock", 1, wbusy);
      wait_ready(n);
      // nine cycles had passed since release before the wait began
      chk("lock_min", 1, n + 9 >= LK);
      chk("lock_max", 1, n + 9 <= LK + 40);
      chk("locked", 1, locked);
      cyc_n(60);
      chk("link_ready", 1, lrdy);
      cmpq("lock");
      // corner and random bursts
      for (int i = 0; i < 8; i++) rw(rnd_a(i), rnd_a(7 - i));
      cmpq("bursts");
      // termination option two
      opt2 = 1'b1;
      cyc_n(10);
      chk("tclk_off", 0, tclk);
      chk("tdata_on", 1, tdata);
      opt2 = 1'b0;
      cyc_n(10);
      chk("tclk_on", 1, tclk);
      $display("test termination done");
      // bypass at run time keeps ready
      dll_en = 1'b0;
      cyc_n(10);
      chk("bypass", 1, bypass);
      chk("bp_ready", 1, ready);
      chk("bp_unlocked", 0, locked);
      rw(rnd_a(8), rnd_a(9));
      cmpq("bypass");
      // dll reset by doff rise, doff pulse and clock stop
      for (int m = 0; m < 3; m++) begin
         if (m == 0) dll_en = 1'b1;
         if (m == 1) dll_rst = 1'b1;
         if (m == 2) kstop = 1'b1;
         cyc_n(m == 2 ? 20 : 1);
         dll_rst = 1'b0;
         kstop = 1'b0;
         cyc_n(16);
         chk("relock_drop", 0, ready);
         wait_ready(n);
         chk("relock_min", 1, n >= LK - 40);
         chk("relock_max", 1, n <= LK + 40);
         cyc_n(12);
         rw(rnd_a(10), rnd_a(11));
         cmpq("dll_reset");
      end
      // start-up with the dll bypassed throughout
      dll_en = 1'b0;
      rst_in = 1'b1;
      cyc_n(20);
      rst_in = 1'b0;
      wait_ready(n);
      chk("bp_lock_min", 1, n >= LK - 4);
      chk("bp_lock_max", 1, n <= LK + 40);
      cyc_n(12);
      chk("bp_flag", 1, bypass);
      rw(rnd_a(12), rnd_a(13));
      cmpq("bypass_start");
      end_of_test();
   end
endmodule : qdr_sram_dll_init_and_burst_ctl_tb_top
